// ==== rtl/sru_top.sv ====
/*
 serial receiver unit top: avalon-mm registers, status flags, wakeup, interrupts.
 assumes a transmitter elsewhere drives the tx hand-over inputs; stop_i freezes the tick and blocks bus access.
*/
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sru_top
   import sru_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [7:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   input wire logic rxd_i,
   input wire logic tx_handover_i,
   input wire logic tx_idle_i,
   input wire logic stop_i,
   output logic [8:0] tx_data_o,
   output logic tx_load_o,
   output logic rx_irq_o,
   output logic tx_irq_o,
   output logic err_irq_o,
   output logic wake_o
);
   import sru_pkg::*;
   logic [4:0] c1_q;
   logic [4:0] c2_q;
   logic [3:0] c3_q;
   logic [7:0] s1_q;
   logic [8:0] buf_q;
   logic [15:0] baud_q;
   logic ack_q;
   logic tick;
   logic done;
   logic idle_ev;
   sru_char_t ch;
   logic rd_data;
   logic wr_c2;
   logic wr_data;
   logic standby_set;
   logic addr_wake;
   logic quiet_wake;
   logic rx_req;
   logic tx_req;
   logic err_req;
   logic access;
   assign access = (read_i | write_i) & !ack_q & !stop_i;
   assign rd_data = access & read_i & (address_i == SRU_OFS_DATA);
   assign wr_c2 = access & write_i & (address_i == SRU_OFS_CONTROL_TWO);
   assign wr_data = access & write_i & (address_i == SRU_OFS_DATA);
   assign standby_set = wr_c2 & writedata_i[SRU_C2_STANDBY] & !c2_q[SRU_C2_STANDBY];

   // RULE21: stop freezes the tick, registers hold
   sru_tick_gen #(.WIDTH(16)) u_tick (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .run_i(!stop_i),
      .div_i(baud_q),
      .tick_o(tick)
   );
   sru_rx_core u_rx (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .rxd_i(rxd_i),
      .nine_i(c1_q[SRU_C1_NINE]),
      .par_en_i(c1_q[SRU_C1_PAR_EN]),
      .par_odd_i(c1_q[SRU_C1_PAR_ODD]),
      .idle_sel_i(c1_q[SRU_C1_IDLE_SEL]),
      .char_o(ch),
      .done_o(done),
      .idle_o(idle_ev)
   );

   // RULE8: address mark wakes
   assign addr_wake = done & c1_q[SRU_C1_ADDR_WAKE] & c2_q[SRU_C2_STANDBY] &
      (c1_q[SRU_C1_NINE] ? ch.data[8] : ch.data[7]);
   // RULE9: idle wakes without flags
   assign quiet_wake = idle_ev & !c1_q[SRU_C1_ADDR_WAKE] & c2_q[SRU_C2_STANDBY];

   // avalon-mm: one wait cycle, answer at the second edge
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         waitrequest_o <= 1'b1;
         readdata_o <= '0;
      end else begin
         ack_q <= access;
         waitrequest_o <= !access;
         if (access && read_i) begin
            if (address_i == SRU_OFS_CONTROL_ONE) begin
               readdata_o <= {27'h0, c1_q};
            end else if (address_i == SRU_OFS_CONTROL_TWO) begin
               readdata_o <= {27'h0, c2_q};
            end else if (address_i == SRU_OFS_CONTROL_THREE) begin
               readdata_o <= {28'h0, c3_q};
            end else if (address_i == SRU_OFS_STATUS_ONE) begin
               readdata_o <= {24'h0, s1_q};
            end else if (address_i == SRU_OFS_DATA) begin
               readdata_o <= {23'h0, buf_q};
            end else if (address_i == SRU_OFS_BAUD) begin
               readdata_o <= {16'h0, baud_q};
            end else begin
               readdata_o <= SRU_UNMAPPED;
            end
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         c1_q <= '0;
         c3_q <= '0;
         baud_q <= SRU_BAUD_RST;
      end else if (access && write_i) begin
         if (address_i == SRU_OFS_CONTROL_ONE) begin
            c1_q <= writedata_i[4:0];
         end else if (address_i == SRU_OFS_CONTROL_THREE) begin
            c3_q <= writedata_i[3:0];
         end else if (address_i == SRU_OFS_BAUD) begin
            baud_q <= writedata_i[15:0];
         end
      end
   end

   // standby bit: software sets, wakeup clears; wake wins the same cycle
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         c2_q <= '0;
      end else begin
         if (wr_c2) begin
            c2_q <= writedata_i[4:0];
         end
         // RULE11: already idle line wakes again
         if (addr_wake || quiet_wake ||
             (standby_set && !c1_q[SRU_C1_ADDR_WAKE] && s1_q[SRU_S1_IDLE])) begin
            c2_q[SRU_C2_STANDBY] <= 1'b0;
         end
      end
   end

   // receive buffer and status flags; set beats clear, except done, which a data write keeps clear
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q <= 8'hc0;
         buf_q <= '0;
         tx_data_o <= '0;
         tx_load_o <= 1'b0;
      end else begin
         tx_load_o <= 1'b0;
         if (rd_data) begin
            s1_q[SRU_S1_FULL:SRU_S1_PE] <= '0;
         end
         if (wr_data) begin
            tx_data_o <= writedata_i[8:0];
            tx_load_o <= 1'b1;
            s1_q[SRU_S1_TXE] <= 1'b0;
            s1_q[SRU_S1_DONE] <= 1'b0;
         end
         // RULE12: hand-over empties buffer
         if (tx_handover_i) begin
            s1_q[SRU_S1_TXE] <= 1'b1;
         end
         // RULE13: shifter idle and buffer empty
         if (tx_idle_i && s1_q[SRU_S1_TXE] && !wr_data) begin
            s1_q[SRU_S1_DONE] <= 1'b1;
         end
         if (done && (!c2_q[SRU_C2_STANDBY] || addr_wake)) begin
            if (s1_q[SRU_S1_FULL] && !rd_data) begin
               // RULE16: keep old, drop new
               s1_q[SRU_S1_OR] <= 1'b1;
            end else begin
               // RULE14: character into buffer
               // RULE3: framing with full
               buf_q <= ch.data;
               s1_q[SRU_S1_FULL] <= 1'b1;
               s1_q[SRU_S1_FE] <= ch.frame;
               // RULE17: noise on any bit
               s1_q[SRU_S1_NF] <= ch.noise;
               s1_q[SRU_S1_PE] <= ch.parity;
            end
         end
         if (idle_ev && !c2_q[SRU_C2_STANDBY]) begin
            s1_q[SRU_S1_IDLE] <= 1'b1;
         end
      end
   end

   // RULE7: standby hides receiver requests
   assign rx_req = !c2_q[SRU_C2_STANDBY] &
      ((s1_q[SRU_S1_FULL] & c2_q[SRU_C2_RX_IE]) | (s1_q[SRU_S1_IDLE] & c2_q[SRU_C2_QUIET_IE]));
   assign tx_req = (s1_q[SRU_S1_TXE] & c2_q[SRU_C2_TX_IE]) |
      (s1_q[SRU_S1_DONE] & c2_q[SRU_C2_DONE_IE]);
   // RULE19: framing enable gates error irq
   assign err_req = !c2_q[SRU_C2_STANDBY] &
      ((s1_q[SRU_S1_OR] & c3_q[SRU_C3_OVR_IE]) | (s1_q[SRU_S1_NF] & c3_q[SRU_C3_NOISE_IE]) |
       (s1_q[SRU_S1_FE] & c3_q[SRU_C3_FRM_IE]) | (s1_q[SRU_S1_PE] & c3_q[SRU_C3_PAR_IE]));

   // RULE24: or of enabled flags
   // RULE20: any request ends wait
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_irq_o <= 1'b0;
         tx_irq_o <= 1'b0;
         err_irq_o <= 1'b0;
         wake_o <= 1'b0;
      end else begin
         rx_irq_o <= rx_req;
         tx_irq_o <= tx_req;
         err_irq_o <= err_req;
         wake_o <= rx_req | tx_req | err_req;
      end
   end

   standby_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      c2_q[SRU_C2_STANDBY] |=> !rx_irq_o) // RULE7
      else $error("receiver irq raised in standby");
   frame_with_full_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(s1_q[SRU_S1_FE]) |-> $rose(s1_q[SRU_S1_FULL])) // RULE3
      else $error("framing error without buffer full");
   overrun_keeps_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(s1_q[SRU_S1_OR]) |-> $stable(buf_q)) // RULE16
      else $error("overrun changed buffer");
   quiet_no_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      quiet_wake |=> !$rose(s1_q[SRU_S1_IDLE]) && !$rose(s1_q[SRU_S1_FULL])) // RULE9
      else $error("idle wakeup set a flag");
   addr_wake_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      addr_wake && !s1_q[SRU_S1_FULL] |=> s1_q[SRU_S1_FULL] && !c2_q[SRU_C2_STANDBY]) // RULE8
      else $error("address mark did not wake");
   tx_irq_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      s1_q[SRU_S1_TXE] && c2_q[SRU_C2_TX_IE] |=> tx_irq_o) // RULE12
      else $error("tx empty irq missing");
   err_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      s1_q[SRU_S1_FE] && c3_q[SRU_C3_FRM_IE] && !c2_q[SRU_C2_STANDBY] |=> err_irq_o) // RULE19
      else $error("framing irq missing");
   rx_full_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      done && !c2_q[SRU_C2_STANDBY] && !s1_q[SRU_S1_FULL] |=> s1_q[SRU_S1_FULL]) // RULE14
      else $error("buffer full not set");
   bus_answer_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (read_i || write_i) && !stop_i && waitrequest_o |-> ##[0:2] !waitrequest_o)
      else $error("bus answer late");
   char_done_c: cover property (@(posedge mclk_i) disable iff (rst_i) done);
   overrun_c: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(s1_q[SRU_S1_OR]));
   wake_c: cover property (@(posedge mclk_i) disable iff (rst_i) quiet_wake || addr_wake);
endmodule : sru_top
`default_nettype wire

// ==== rtl/sru_pkg.sv ====
/*
 serial receiver unit package: register map, field positions, reset values, timing.
 assumes an avalon-mm slave with 32-bit data and word-aligned byte addresses.
*/
// Operation
// RULE1: framing error flag sets when the stop sample is not 1.
// RULE2: a break character, lacking a stop bit, sets framing error.
// RULE3: framing error sets in the same cycle as buffer full.
// RULE4: one disagreeing stop sample gives noise; two or more give framing error.
// RULE5: tick counter resynchronises on every valid falling edge inside a character.
// RULE6: sixteen ticks per bit; stop decided from ticks 8, 9 and 10.
// RULE7: standby bit suppresses all receiver interrupt requests.
// RULE8: address-mark wakeup: msb 1 clears standby and sets buffer full.
// RULE9: idle-line wakeup: idle clears standby, sets neither idle nor full.
// RULE10: idle line type picks count start: after start or after stop bit.
// RULE11: setting standby on an already idle line wakes the receiver again.
// RULE12: tx empty sets on hand-over to shifter; interrupts when enabled.
// RULE13: transfer done sets when shifter and buffer empty, no break/idle; enabled irq.
// RULE14: buffer full sets on character moved into data buffer; enabled irq.
// RULE15: idle flag sets after 10 or 11 ones; enabled interrupt.
// RULE16: overrun keeps old character, discards new, sets overrun flag.
// RULE17: noise flag sets on noise in start, data or stop bits; own enable.
// RULE18: parity error flag sets on failed parity; own interrupt enable.
// RULE19: framing interrupt enable gates framing error onto error interrupt.
// RULE20: block runs in wait state; enabled requests can end it.
// RULE21: stop mode halts with registers kept; resumes afterwards.
// RULE22: oversample tick runs at sixteen times the baud rate.
// RULE23: stop bit by majority; majority 0 framing error, disagreement noise.
// RULE24: each interrupt output is the or of enabled flags, held until cleared.
package sru_pkg;
   localparam logic [7:0] SRU_OFS_CONTROL_ONE = 8'h00;
   localparam logic [7:0] SRU_OFS_CONTROL_TWO = 8'h04;
   localparam logic [7:0] SRU_OFS_CONTROL_THREE = 8'h08;
   localparam logic [7:0] SRU_OFS_STATUS_ONE = 8'h0c;
   localparam logic [7:0] SRU_OFS_DATA = 8'h10;
   localparam logic [7:0] SRU_OFS_BAUD = 8'h14;
   localparam logic [7:0] SRU_OFS_TXCTL = 8'h18;
   localparam logic [31:0] SRU_UNMAPPED = 32'h0000_0000;
   localparam logic [15:0] SRU_BAUD_RST = 16'h0019;
   localparam logic [3:0] SRU_TICKS_PER_BIT = 4'hf;
   localparam logic [3:0] SRU_START_S0 = 4'h3;
   localparam logic [3:0] SRU_START_S1 = 4'h5;
   localparam logic [3:0] SRU_START_S2 = 4'h7;
   localparam logic [3:0] SRU_BIT_S0 = 4'h8;
   localparam logic [3:0] SRU_BIT_S1 = 4'h9;
   localparam logic [3:0] SRU_BIT_S2 = 4'ha;
   localparam logic [3:0] SRU_IDLE_8 = 4'ha;
   localparam logic [3:0] SRU_IDLE_9 = 4'hb;
   // control_one bits
   localparam int SRU_C1_NINE = 0;
   localparam int SRU_C1_ADDR_WAKE = 1;
   localparam int SRU_C1_IDLE_SEL = 2;
   localparam int SRU_C1_PAR_EN = 3;
   localparam int SRU_C1_PAR_ODD = 4;
   // control_two bits
   localparam int SRU_C2_TX_IE = 0;
   localparam int SRU_C2_DONE_IE = 1;
   localparam int SRU_C2_RX_IE = 2;
   localparam int SRU_C2_QUIET_IE = 3;
   localparam int SRU_C2_STANDBY = 4;
   // control_three bits
   localparam int SRU_C3_OVR_IE = 0;
   localparam int SRU_C3_NOISE_IE = 1;
   localparam int SRU_C3_FRM_IE = 2;
   localparam int SRU_C3_PAR_IE = 3;
   // status_one bits
   localparam int SRU_S1_PE = 0;
   localparam int SRU_S1_FE = 1;
   localparam int SRU_S1_NF = 2;
   localparam int SRU_S1_OR = 3;
   localparam int SRU_S1_IDLE = 4;
   localparam int SRU_S1_FULL = 5;
   localparam int SRU_S1_DONE = 6;
   localparam int SRU_S1_TXE = 7;
   typedef struct packed {
      logic [8:0] data;
      logic noise;
      logic frame;
      logic parity;
   } sru_char_t;
   typedef enum logic [1:0] {SRU_HUNT, SRU_START, SRU_DATA, SRU_STOP} sru_state_t;
endpackage : sru_pkg

// ==== rtl/sru_tick_gen.sv ====
/*
 oversample tick generator: one-cycle pulse every divisor+1 clocks.
 assumes the divisor is set for sixteen ticks per bit time.
*/
`timescale 1ns/100ps
`default_nettype none
module sru_tick_gen #(
   parameter int WIDTH = 16
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic [WIDTH-1:0] div_i,
   output logic tick_o
);
   logic [WIDTH-1:0] cnt_q;
   // RULE22: sixteen ticks per bit
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         tick_o <= 1'b0;
      end else if (!run_i) begin
         tick_o <= 1'b0;
      end else if (cnt_q >= div_i) begin
         cnt_q <= '0;
         tick_o <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick_o <= 1'b0;
      end
   end
endmodule : sru_tick_gen
`default_nettype wire

// ==== rtl/sru_rx_core.sv ====
/*
 receive recovery: start search, 3-sample majority, stop check, idle count.
 assumes rxd_i synchronous and tick_i one clock wide at 16x baud.
*/
`timescale 1ns/100ps
`default_nettype none
module sru_rx_core
   import sru_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic rxd_i,
   input wire logic nine_i,
   input wire logic par_en_i,
   input wire logic par_odd_i,
   input wire logic idle_sel_i,
   output sru_pkg::sru_char_t char_o,
   output logic done_o,
   output logic idle_o
);
   import sru_pkg::*;
   sru_state_t st_q;
   logic [3:0] rt_q;
   logic [3:0] nbit_q;
   logic [2:0] smp_q;
   logic [2:0] hist_q;
   logic [8:0] shf_q;
   logic noise_q;
   logic prev_q;
   logic [3:0] ones_q;
   logic idle_arm_q;
   logic [3:0] quiet_rt_q;
   function automatic logic maj3(input logic [2:0] s);
      return (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
   endfunction : maj3
   function automatic logic dis3(input logic [2:0] s);
      return (s != 3'b000) && (s != 3'b111);
   endfunction : dis3
   logic [3:0] nbits;
   logic bitv;
   logic [2:0] s3;
   assign nbits = nine_i ? 4'h9 : 4'h8;
   assign s3 = {smp_q[1:0], rxd_i};
   assign bitv = maj3(s3);
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= SRU_HUNT;
         rt_q <= '0;
         nbit_q <= '0;
         smp_q <= '0;
         hist_q <= 3'b000;
         shf_q <= '0;
         noise_q <= 1'b0;
         prev_q <= 1'b1;
         char_o <= '0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (tick_i) begin
            hist_q <= {hist_q[1:0], rxd_i};
            rt_q <= rt_q + 1'b1;
            if (rt_q == SRU_START_S0 || rt_q == SRU_START_S1 || rt_q == SRU_START_S2 ||
                rt_q == SRU_BIT_S0 || rt_q == SRU_BIT_S1) begin
               smp_q <= {smp_q[1:0], rxd_i};
            end
            case (st_q)
               SRU_HUNT: begin
                  rt_q <= 4'h1;
                  if (hist_q == 3'b111 && !rxd_i) begin
                     st_q <= SRU_START;
                     noise_q <= 1'b0;
                     nbit_q <= '0;
                  end
               end
               SRU_START: begin
                  if (rt_q == SRU_START_S2) begin
                     if (maj3(s3)) begin
                        st_q <= SRU_HUNT;
                     end else if (dis3(s3)) begin
                        noise_q <= 1'b1;
                     end
                  end
                  if (rt_q == SRU_BIT_S2 && s3 != 3'b000) begin
                     noise_q <= 1'b1;
                  end
                  if (rt_q == SRU_TICKS_PER_BIT) begin
                     st_q <= SRU_DATA;
                     prev_q <= 1'b0;
                  end
               end
               SRU_DATA: begin
                  // RULE5: resync on falling edge
                  if (prev_q && !rxd_i && rt_q > SRU_BIT_S2) begin
                     rt_q <= 4'h1;
                     nbit_q <= nbit_q + 1'b1;
                     if (nbit_q + 1'b1 == nbits) begin
                        st_q <= SRU_STOP;
                     end
                  end else if (rt_q == SRU_TICKS_PER_BIT) begin
                     nbit_q <= nbit_q + 1'b1;
                     if (nbit_q + 1'b1 == nbits) begin
                        st_q <= SRU_STOP;
                     end
                  end
                  if (rt_q == SRU_BIT_S2) begin
                     prev_q <= bitv;
                     shf_q <= nine_i ? {bitv, shf_q[8:1]} : {1'b0, bitv, shf_q[7:1]};
                     if (dis3(s3)) begin
                        noise_q <= 1'b1;
                     end
                  end
               end
               SRU_STOP: begin
                  // RULE6: stop sampled at ticks 8..10
                  if (rt_q == SRU_BIT_S2) begin
                     st_q <= SRU_HUNT;
                     done_o <= 1'b1;
                     char_o.data <= shf_q;
                     // RULE4: one bad sample noise, more framing
                     // RULE23: majority vote on stop
                     char_o.noise <= noise_q | dis3(s3);
                     // RULE1: stop not one
                     // RULE2: break has no stop bit
                     char_o.frame <= !bitv;
                     // RULE18: parity over the shifted data bits
                     char_o.parity <= par_en_i & ((^shf_q) ^ par_odd_i);
                  end
               end
               default: st_q <= SRU_HUNT;
            endcase
         end
      end
   end
   // RULE10: idle count from start or stop bit
   // RULE15: 10 or 11 ones make idle
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ones_q <= '0;
         idle_arm_q <= 1'b1;
         idle_o <= 1'b0;
         quiet_rt_q <= '0;
      end else begin
         idle_o <= 1'b0;
         // bit timer for idle counting while hunting
         if (st_q != SRU_HUNT) begin
            quiet_rt_q <= '0;
         end else if (tick_i) begin
            quiet_rt_q <= quiet_rt_q + 1'b1;
         end
         if (tick_i && rt_q == SRU_BIT_S2 && st_q != SRU_HUNT && st_q != SRU_START) begin
            if (!bitv || (idle_sel_i && st_q == SRU_DATA)) begin
               ones_q <= '0;
            end else if (ones_q != SRU_IDLE_9) begin
               ones_q <= ones_q + 1'b1;
            end
         end else if (tick_i && st_q == SRU_HUNT && quiet_rt_q == SRU_TICKS_PER_BIT) begin
            if (!rxd_i) begin
               ones_q <= '0;
            end else if (ones_q != SRU_IDLE_9) begin
               ones_q <= ones_q + 1'b1;
            end
         end
         if (st_q == SRU_START) begin
            ones_q <= '0;
            idle_arm_q <= 1'b1;
         end
         if (idle_arm_q && ones_q == (nine_i ? SRU_IDLE_9 : SRU_IDLE_8)) begin
            idle_o <= 1'b1;
            idle_arm_q <= 1'b0;
         end
      end
   end
   st_start_c: cover property (@(posedge mclk_i) disable iff (rst_i) st_q == SRU_START);
endmodule : sru_rx_core
`default_nettype wire

// ==== verif/sru_line_model.sv ====
/*
 far-end serial transmitter model: sends framed characters on rxd.
 assumes the caller enters send just after a rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module sru_line_model #(
   parameter int BIT_CLKS = 16
) (
   input wire logic mclk_i,
   output logic rxd_o
);
   initial rxd_o = 1'b1;
   task automatic bit_out(input logic v);
      rxd_o <= v;
      repeat (BIT_CLKS) @(posedge mclk_i);
   endtask : bit_out
   task automatic send(input logic [8:0] d, input int n, input logic stp);
      bit_out(1'b0);
      for (int i = 0; i < n; i++) begin
         bit_out(d[i]);
      end
      bit_out(stp);
      bit_out(1'b1);
   endtask : send
endmodule : sru_line_model
`default_nettype wire

// ==== verif/testbench.sv ====
/*
 self-checking bench for the serial receiver unit top.
 assumes baud divisor 0, so one tick per clock and 16 clocks per bit.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import sru_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] address_i = 8'h00;
   logic read_i = 1'b0;
   logic write_i = 1'b0;
   logic [31:0] writedata_i = 32'h0;
   logic tx_handover_i = 1'b0;
   logic tx_idle_i = 1'b1;
   logic stop_i = 1'b0;
   logic [31:0] readdata_o;
   logic waitrequest_o;
   logic rxd_i;
   logic [8:0] tx_data_o;
   logic tx_load_o;
   logic rx_irq_o;
   logic tx_irq_o;
   logic err_irq_o;
   logic wake_o;
   logic [8:0] last_tx = 9'h000;
   logic [31:0] q;
   int errors = 0;
   int total_checks = 0;
   always #12.5 mclk_i = ~mclk_i;
   sru_top DUT(.mclk_i, .rst_i, .address_i, .read_i, .write_i, .writedata_i,
      .readdata_o, .waitrequest_o, .rxd_i, .tx_handover_i, .tx_idle_i, .stop_i,
      .tx_data_o, .tx_load_o, .rx_irq_o, .tx_irq_o, .err_irq_o, .wake_o);
   sru_line_model line(.mclk_i(mclk_i), .rxd_o(rxd_i));
   always @(posedge mclk_i) if (tx_load_o === 1'b1) last_tx <= tx_data_o;
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      address_i <= a;
      writedata_i <= d;
      read_i <= !wr;
      write_i <= wr;
      do begin
         @(posedge mclk_i);
         n++;
      end while (waitrequest_o !== 1'b0 && n < 60);
      q = readdata_o;
      read_i <= 1'b0;
      write_i <= 1'b0;
      @(posedge mclk_i);
      if (n >= 60) begin
         errors++;
         print_verdict();
      end
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask : rd
   task automatic settle;
      repeat (3) @(posedge mclk_i);
   endtask : settle
   task automatic s_reset;
      rd(SRU_OFS_STATUS_ONE);
      chk(q & 32'hff, 32'hc0);
      chk({rx_irq_o, tx_irq_o, err_irq_o}, 32'h0);
      rd(SRU_UNMAPPED[7:0] + 8'hfc);
      chk(q, 32'h0);
      wr(SRU_OFS_BAUD, 32'h0);
   endtask : s_reset
   task automatic s_good;
      wr(SRU_OFS_CONTROL_THREE, 32'h1 << SRU_C3_FRM_IE);
      wr(SRU_OFS_CONTROL_TWO, 32'h1 << SRU_C2_RX_IE);
      line.send(9'h05a, 8, 1'b1);
      rd(SRU_OFS_STATUS_ONE);
      chk(q[SRU_S1_FULL], 32'h1);
      chk(q[SRU_S1_FE], 32'h0);
      chk({rx_irq_o, err_irq_o}, 32'h2);
      rd(SRU_OFS_DATA);
      chk(q[7:0], 32'h5a);
      settle();
      chk(rx_irq_o, 32'h0);
   endtask : s_good
   task automatic s_frame(input logic [8:0] d);
      line.send(d, 8, 1'b0);
      rd(SRU_OFS_STATUS_ONE);
      chk({q[SRU_S1_FULL], q[SRU_S1_FE]}, 32'h3);
      chk(err_irq_o, 32'h1);
      rd(SRU_OFS_DATA);
      settle();
      chk(err_irq_o, 32'h0);
   endtask : s_frame
   task automatic s_overrun;
      wr(SRU_OFS_CONTROL_THREE, 32'h1 << SRU_C3_OVR_IE);
      line.send(9'h011, 8, 1'b1);
      line.send(9'h022, 8, 1'b1);
      rd(SRU_OFS_STATUS_ONE);
      chk(q[SRU_S1_OR], 32'h1);
      chk(err_irq_o, 32'h1);
      rd(SRU_OFS_DATA);
      chk(q[7:0], 32'h11);
   endtask : s_overrun
   task automatic s_parity;
      wr(SRU_OFS_CONTROL_ONE, 32'h1 << SRU_C1_PAR_EN);
      wr(SRU_OFS_CONTROL_THREE, 32'h1 << SRU_C3_PAR_IE);
      line.send(9'h007, 8, 1'b1);
      rd(SRU_OFS_STATUS_ONE);
      chk({q[SRU_S1_PE], q[SRU_S1_FE]}, 32'h2);
      chk(err_irq_o, 32'h1);
      rd(SRU_OFS_DATA);
   endtask : s_parity
   task automatic s_wake;
      wr(SRU_OFS_CONTROL_ONE, 32'h1 << SRU_C1_ADDR_WAKE);
      wr(SRU_OFS_CONTROL_TWO, (32'h1 << SRU_C2_STANDBY) | (32'h1 << SRU_C2_RX_IE));
      line.send(9'h012, 8, 1'b1);
      rd(SRU_OFS_STATUS_ONE);
      chk({q[SRU_S1_FULL], rx_irq_o}, 32'h0);
      line.send(9'h092, 8, 1'b1);
      rd(SRU_OFS_STATUS_ONE);
      chk(q[SRU_S1_FULL], 32'h1);
      rd(SRU_OFS_CONTROL_TWO);
      chk(q[SRU_C2_STANDBY], 32'h0);
      chk(rx_irq_o, 32'h1);
      rd(SRU_OFS_DATA);
      chk(q[7:0], 32'h92);
   endtask : s_wake
   task automatic s_idle;
      wr(SRU_OFS_CONTROL_ONE, 32'h0);
      wr(SRU_OFS_CONTROL_TWO, (32'h1 << SRU_C2_RX_IE) | (32'h1 << SRU_C2_QUIET_IE));
      repeat (200) @(posedge mclk_i);
      rd(SRU_OFS_STATUS_ONE);
      chk(q[SRU_S1_IDLE], 32'h1);
      chk(rx_irq_o, 32'h1);
      wr(SRU_OFS_CONTROL_TWO, (32'h1 << SRU_C2_STANDBY) | (32'h1 << SRU_C2_RX_IE));
      rd(SRU_OFS_CONTROL_TWO);
      chk(q[SRU_C2_STANDBY], 32'h0);
      rd(SRU_OFS_DATA);
      wr(SRU_OFS_CONTROL_TWO, (32'h1 << SRU_C2_STANDBY) | (32'h1 << SRU_C2_RX_IE));
      rd(SRU_OFS_CONTROL_TWO);
      chk(q[SRU_C2_STANDBY], 32'h1);
      line.send(9'h033, 8, 1'b1);
      repeat (200) @(posedge mclk_i);
      rd(SRU_OFS_STATUS_ONE);
      chk({q[SRU_S1_FULL], q[SRU_S1_IDLE]}, 32'h0);
      rd(SRU_OFS_CONTROL_TWO);
      chk(q[SRU_C2_STANDBY], 32'h0);
   endtask : s_idle
   task automatic s_tx;
      wr(SRU_OFS_CONTROL_TWO, 32'h1 << SRU_C2_TX_IE);
      settle();
      chk({tx_irq_o, wake_o}, 32'h3);
      wr(SRU_OFS_DATA, 32'h1a5);
      settle();
      chk(last_tx, 32'h1a5);
      rd(SRU_OFS_STATUS_ONE);
      chk({q[SRU_S1_TXE], tx_irq_o}, 32'h0);
      tx_handover_i <= 1'b1;
      @(posedge mclk_i);
      tx_handover_i <= 1'b0;
      settle();
      chk({tx_irq_o, wake_o}, 32'h3);
      rd(SRU_OFS_STATUS_ONE);
      chk(q[SRU_S1_DONE], 32'h1);
   endtask : s_tx
   initial begin
      repeat (5) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      s_reset();
      s_good();
      s_frame(9'h0ff);
      s_frame(9'h000);
      s_overrun();
      s_parity();
      s_wake();
      s_idle();
      s_tx();
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
